// [shared/tar_defs.svh]
`ifndef TAR_DEFS_SVH
`define TAR_DEFS_SVH

// Command codes of the registers that this block holds.
`define TAR_CMD_STATUS   8'h02
`define TAR_CMD_CONFIG   8'h09
`define TAR_CMD_ONESHOT  8'h0f
`define TAR_CMD_ABS      8'hbf
`define TAR_CMD_MAKER    8'hfe
`define TAR_CMD_REVISION 8'hff

// Shared alert response address.
`define TAR_ARA_ADDR     7'h0c

// Field positions.
`define TAR_MASK_BIT     3'd7
`define TAR_MODE_BIT     3'd0
`define TAR_BUSY_BIT     3'd7
`define TAR_LHIGH_BIT    3'd6
`define TAR_LLOW_BIT     3'd5
`define TAR_RHIGH_BIT    3'd4
`define TAR_RLOW_BIT     3'd3
`define TAR_OPEN_BIT     3'd2
`define TAR_RCRIT_BIT    3'd1
`define TAR_LCRIT_BIT    3'd0

// Status bits that may drive the alert line: all but busy and open diode.
`define TAR_ALARM_BITS   8'h7b

// Reset and fixed read values.
`define TAR_CONFIG_RST   8'h00
`define TAR_STATUS_RST   8'h00
`define TAR_BYTE_RST     8'h00
`define TAR_READ_ONES    8'hff
`define TAR_ABS_HIGH     7'h00

// Serial engine counts.
`define TAR_BYTE_BITS    4'h8
`define TAR_CNT_RST      4'h0

// Arbitrary identity defaults.
`define TAR_MAKER_DEFAULT    8'h5c
`define TAR_REVISION_DEFAULT 8'h03
`define TAR_SLAVE_DEFAULT    7'h4c

`endif

// [shared/tar_pkg.sv]
package tar_pkg;

  typedef enum logic [2:0] {
    SMB_IDLE,
    SMB_ADDR,
    SMB_ADDR_ACK,
    SMB_WR,
    SMB_WR_ACK,
    SMB_RD,
    SMB_RD_ACK
  } tar_smb_state_type;

  typedef logic [7:0] tar_byte_type;

endpackage : tar_pkg

// [shared/tar_alarm_if.sv]
`timescale 1ns/100ps
interface tar_alarm_if;
  import tar_pkg::*;

  logic         meas_stb;
  tar_byte_type local_temp;
  tar_byte_type remote_temp;
  tar_byte_type local_high;
  tar_byte_type local_low;
  tar_byte_type local_crit;
  tar_byte_type remote_high;
  tar_byte_type remote_low;
  tar_byte_type remote_crit;
  logic         remote_open;
  tar_byte_type alarm_bits;
  logic         alarm_stb;

  modport eval (
    input  meas_stb, local_temp, remote_temp, local_high, local_low, local_crit,
    input  remote_high, remote_low, remote_crit, remote_open,
    output alarm_bits, alarm_stb
  );

  modport core (
    output meas_stb, local_temp, remote_temp, local_high, local_low, local_crit,
    output remote_high, remote_low, remote_crit, remote_open,
    input  alarm_bits, alarm_stb
  );

endinterface : tar_alarm_if

// [src/tar_pin_sync.sv]
`timescale 1ns/100ps
module tar_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage_r;

  // ****************************************************************
  // Two flip-flop synchroniser; the pins idle high on an open-drain bus.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_r  <= '1;
      pin_sync <= '1;
    end
    else
    begin
      stage_r  <= pin_in;
      pin_sync <= stage_r;
    end
  end

endmodule : tar_pin_sync

// [src/tar_alarm_eval.sv]
`timescale 1ns/100ps
`include "tar_defs.svh"
module tar_alarm_eval (
  input  wire logic  clk,
  input  wire logic  rst_n,
  tar_alarm_if.eval  alm
);
  import tar_pkg::*;

  function automatic logic above(input tar_byte_type value, input tar_byte_type limit);
    above = $signed(value) > $signed(limit);
  endfunction : above

  function automatic logic below(input tar_byte_type value, input tar_byte_type limit);
    below = $signed(value) < $signed(limit);
  endfunction : below

  tar_byte_type bits_nxt;

  // ****************************************************************
  // Limit comparison of one finished reading.
  // ****************************************************************
  always_comb
  begin
    bits_nxt                 = `TAR_STATUS_RST;
    bits_nxt[`TAR_LHIGH_BIT] = above(alm.local_temp, alm.local_high);
    bits_nxt[`TAR_LLOW_BIT]  = below(alm.local_temp, alm.local_low);
    bits_nxt[`TAR_RHIGH_BIT] = above(alm.remote_temp, alm.remote_high);
    bits_nxt[`TAR_RLOW_BIT]  = below(alm.remote_temp, alm.remote_low);
    bits_nxt[`TAR_OPEN_BIT]  = alm.remote_open;
    bits_nxt[`TAR_RCRIT_BIT] = above(alm.remote_temp, alm.remote_crit);
    bits_nxt[`TAR_LCRIT_BIT] = above(alm.local_temp, alm.local_crit);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alm.alarm_bits <= `TAR_STATUS_RST;
      alm.alarm_stb  <= 1'b0;
    end
    else
    begin
      alm.alarm_stb <= alm.meas_stb;
      if (alm.meas_stb)
      begin
        alm.alarm_bits <= bits_nxt;
      end
    end
  end

endmodule : tar_alarm_eval

// [src/tar_alert_top.sv]
`timescale 1ns/100ps
`include "tar_defs.svh"
// Function
// - Behaviour bit 0: interrupt or comparator mode.
// - Behaviour bits 7..1 read as zero.
// - Maker byte at FEh, revision at FFh.
// - Trigger write in standby, when not busy, starts one conversion.
// - Trigger register stores nothing, reads FFh.
// - Alert is active low, open drain.
// - Each reading sets alarm bits per limit.
// - Unmasked alarm bits pull alert low.
// - Comparator mode releases alert when condition clears.
// - Interrupt-mode status read sets mask on alarm.
// - Interrupt-mode alarm bits clear only by read.
// - Interrupt-mode status read clears, releases, masks together.
// - Alerting devices answer shared address, lowest wins.
// - Sent response address releases alert, sets mask.
// - Answer response reads only in interrupt mode.
// - Response byte is address then a one.
// - Reset clears mask and behaviour bit.
module tar_alert_top #(
  parameter logic [6:0]   SLAVE_ADDR = `TAR_SLAVE_DEFAULT,
  // Identity values below are arbitrary.
  parameter tar_pkg::tar_byte_type MAKER_ID    = `TAR_MAKER_DEFAULT,
  parameter tar_pkg::tar_byte_type REVISION_ID = `TAR_REVISION_DEFAULT
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  output logic                       alert_out,
  output logic                       alert_oe,
  input  wire logic                  meas_stb,
  input  wire tar_pkg::tar_byte_type local_temp,
  input  wire tar_pkg::tar_byte_type remote_temp,
  input  wire tar_pkg::tar_byte_type local_high_limit,
  input  wire tar_pkg::tar_byte_type local_low_limit,
  input  wire tar_pkg::tar_byte_type local_crit_limit,
  input  wire tar_pkg::tar_byte_type remote_high_limit,
  input  wire tar_pkg::tar_byte_type remote_low_limit,
  input  wire tar_pkg::tar_byte_type remote_crit_limit,
  input  wire logic                  remote_open,
  input  wire logic                  conv_busy,
  input  wire logic                  standby,
  output logic                       one_shot_start
);
  import tar_pkg::*;

  // ****************************************************************
  // Reset release.
  // ****************************************************************
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Bus pins and edge detection.
  // ****************************************************************
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_r;
  logic       sda_d_r;

  tar_pin_sync #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .pin_in   ({scl_in, sda_in}),
    .pin_sync (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop  = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;

  // ****************************************************************
  // Limit evaluation.
  // ****************************************************************
  tar_alarm_if alm ();

  assign alm.meas_stb    = meas_stb;
  assign alm.local_temp  = local_temp;
  assign alm.remote_temp = remote_temp;
  assign alm.local_high  = local_high_limit;
  assign alm.local_low   = local_low_limit;
  assign alm.local_crit  = local_crit_limit;
  assign alm.remote_high = remote_high_limit;
  assign alm.remote_low  = remote_low_limit;
  assign alm.remote_crit = remote_crit_limit;
  assign alm.remote_open = remote_open;

  tar_alarm_eval u_eval (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .alm   (alm)
  );

  // ****************************************************************
  // Serial slave engine.
  // ****************************************************************
  tar_smb_state_type state_r;
  logic [3:0]        cnt_r;
  tar_byte_type      shift_r;
  tar_byte_type      tx_r;
  tar_byte_type      cmd_r;
  tar_byte_type      rd_data;
  tar_byte_type      load_byte;
  logic              rw_r;
  logic              ara_r;
  logic              first_r;
  logic              nack_r;
  logic              sda_oe_r;
  logic              byte_done;
  logic              addr_hit;
  logic              ara_hit;
  logic              ara_en;
  logic              cmd_stb;
  logic              wr_stb;
  logic              rd_stb;
  logic              ara_ok;

  assign byte_done = cnt_r == `TAR_BYTE_BITS;
  assign addr_hit  = shift_r[7:1] == SLAVE_ADDR;
  assign ara_hit   = (shift_r[7:1] == `TAR_ARA_ADDR) && shift_r[0] && ara_en;
  assign load_byte = ara_r ? {SLAVE_ADDR, 1'b1} : rd_data;
  assign cmd_stb   = scl_fall && (state_r == SMB_WR) && byte_done && first_r;
  assign wr_stb    = scl_fall && (state_r == SMB_WR) && byte_done && !first_r;
  assign rd_stb    = scl_fall && !ara_r && (((state_r == SMB_ADDR_ACK) && rw_r) ||
                     ((state_r == SMB_RD_ACK) && !nack_r));
  assign ara_ok    = scl_fall && (state_r == SMB_RD) && byte_done && ara_r;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_r  <= SMB_IDLE;
      cnt_r    <= `TAR_CNT_RST;
      shift_r  <= `TAR_BYTE_RST;
      tx_r     <= `TAR_BYTE_RST;
      rw_r     <= 1'b0;
      ara_r    <= 1'b0;
      first_r  <= 1'b0;
      nack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (bus_start)
    begin
      state_r  <= SMB_ADDR;
      cnt_r    <= `TAR_CNT_RST;
      sda_oe_r <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_r  <= SMB_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (state_r)
        SMB_ADDR, SMB_WR:
        begin
          shift_r <= {shift_r[6:0], sda_s};
          cnt_r   <= cnt_r + 4'h1;
        end
        SMB_RD:
        begin
          // A released one seen low means a lower address won the line.
          if (!sda_oe_r && !sda_s)
          begin
            state_r <= SMB_IDLE;
          end
          cnt_r <= cnt_r + 4'h1;
        end
        SMB_RD_ACK:
        begin
          nack_r <= sda_s;
        end
        SMB_IDLE, SMB_ADDR_ACK, SMB_WR_ACK:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        SMB_ADDR:
        begin
          if (byte_done && (addr_hit || ara_hit))
          begin
            state_r  <= SMB_ADDR_ACK;
            sda_oe_r <= 1'b1;
            rw_r     <= shift_r[0];
            ara_r    <= ara_hit;
            first_r  <= !shift_r[0];
          end
          else if (byte_done)
          begin
            state_r <= SMB_IDLE;
          end
        end
        SMB_ADDR_ACK, SMB_RD_ACK:
        begin
          cnt_r <= `TAR_CNT_RST;
          if (state_r == SMB_RD_ACK && nack_r)
          begin
            state_r  <= SMB_IDLE;
            sda_oe_r <= 1'b0;
          end
          else if (state_r == SMB_RD_ACK || rw_r)
          begin
            state_r  <= SMB_RD;
            tx_r     <= {load_byte[6:0], 1'b1};
            sda_oe_r <= !load_byte[7];
          end
          else
          begin
            state_r  <= SMB_WR;
            sda_oe_r <= 1'b0;
          end
        end
        SMB_WR:
        begin
          if (byte_done)
          begin
            state_r  <= SMB_WR_ACK;
            sda_oe_r <= 1'b1;
            first_r  <= 1'b0;
          end
        end
        SMB_WR_ACK:
        begin
          state_r  <= SMB_WR;
          cnt_r    <= `TAR_CNT_RST;
          sda_oe_r <= 1'b0;
        end
        SMB_RD:
        begin
          if (byte_done)
          begin
            state_r  <= SMB_RD_ACK;
            sda_oe_r <= 1'b0;
          end
          else
          begin
            tx_r     <= {tx_r[6:0], 1'b1};
            sda_oe_r <= !tx_r[7];
          end
        end
        SMB_IDLE:
        begin
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_r;

  // ****************************************************************
  // Register file.
  // ****************************************************************
  tar_byte_type config_r;
  logic         comparator_r;
  tar_byte_type status_r;
  logic         shot_r;
  logic         alert_r;
  logic         status_read;
  logic         alarm_seen;

  assign status_read = rd_stb && (cmd_r == `TAR_CMD_STATUS);
  assign alarm_seen  = |(status_r & `TAR_ALARM_BITS);
  assign ara_en      = alert_r && !comparator_r;

  always_comb
  begin
    rd_data = `TAR_READ_ONES;
    unique case (cmd_r)
      `TAR_CMD_STATUS:   rd_data = {conv_busy, status_r[6:0]};
      `TAR_CMD_CONFIG:   rd_data = config_r;
      `TAR_CMD_ABS:      rd_data = {`TAR_ABS_HIGH, comparator_r};
      `TAR_CMD_MAKER:    rd_data = MAKER_ID;
      `TAR_CMD_REVISION: rd_data = REVISION_ID;
      `TAR_CMD_ONESHOT:  rd_data = `TAR_READ_ONES;
      default:           rd_data = `TAR_READ_ONES;
    endcase
  end

  // Command pointer; kept for receive-byte reads.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cmd_r <= `TAR_BYTE_RST;
    end
    else if (cmd_stb)
    begin
      cmd_r <= shift_r;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      comparator_r <= 1'b0;
    end
    else if (wr_stb && cmd_r == `TAR_CMD_ABS)
    begin
      comparator_r <= shift_r[`TAR_MODE_BIT];
    end
  end

  // Hardware mask setting wins over a host write in the same cycle.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      config_r <= `TAR_CONFIG_RST;
    end
    else
    begin
      if (wr_stb && cmd_r == `TAR_CMD_CONFIG)
      begin
        config_r <= shift_r;
      end
      if ((status_read && !comparator_r && alarm_seen) || ara_ok)
      begin
        config_r[`TAR_MASK_BIT] <= 1'b1;
      end
    end
  end

  // A new alarm in the cycle of a status read survives the clear.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      status_r <= `TAR_STATUS_RST;
    end
    else if (comparator_r)
    begin
      if (alm.alarm_stb)
      begin
        status_r <= alm.alarm_bits;
      end
    end
    else
    begin
      status_r <= (status_read ? `TAR_STATUS_RST : status_r) |
                  (alm.alarm_stb ? alm.alarm_bits : `TAR_STATUS_RST);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      shot_r <= 1'b0;
    end
    else
    begin
      shot_r <= wr_stb && (cmd_r == `TAR_CMD_ONESHOT) && standby && !conv_busy;
    end
  end

  assign one_shot_start = shot_r;

  // ****************************************************************
  // Alert pin.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      alert_r <= 1'b0;
    end
    else
    begin
      // A status read in comparator mode must not release the line, even for one cycle.
      alert_r <= alarm_seen && !config_r[`TAR_MASK_BIT] &&
                 !(status_read && !comparator_r) && !ara_ok;
    end
  end

  assign alert_out = 1'b0;
  assign alert_oe  = alert_r;

endmodule : tar_alert_top

// [testbench/tar_alert_sva.sv]
`timescale 1ns/100ps
// ******
// Alert pin, data pin and one-shot checks.
// ******
module tar_alert_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic meas_stb,
  input wire logic conv_busy,
  input wire logic standby,
  input wire logic one_shot_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_open_drain;
    !alert_out && !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");

  property p_reset_idle;
    $rose(rst_n) |-> (!alert_oe && !sda_oe && !one_shot_start) [*3];
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("active output after reset");

  property p_shot_pulse;
    one_shot_start |=> !one_shot_start;
  endproperty
  a_shot_pulse: assert property (p_shot_pulse)
    else $error("start pulse too long");

  property p_shot_cause;
    one_shot_start |-> $past(standby) && !$past(conv_busy);
  endproperty
  a_shot_cause: assert property (p_shot_cause)
    else $error("start outside standby");

  property p_shot_bus;
    one_shot_start |-> !scl_in;
  endproperty
  a_shot_bus: assert property (p_shot_bus)
    else $error("start not tied to a write");

  property p_alert_rise;
    $rose(alert_oe) |-> $past(meas_stb, 3) || !scl_in;
  endproperty
  a_alert_rise: assert property (p_alert_rise)
    else $error("alert raised without cause");

  property p_alert_fall;
    $fell(alert_oe) |-> $past(meas_stb, 3) || !scl_in;
  endproperty
  a_alert_fall: assert property (p_alert_fall)
    else $error("alert released without cause");

  property p_sda_stands;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_stands: assert property (p_sda_stands)
    else $error("data moved while clock high");
endmodule : tar_alert_sva

bind tar_alert_top tar_alert_sva u_sva (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .alert_out(alert_out), .alert_oe(alert_oe), .meas_stb(meas_stb), .conv_busy(conv_busy),
  .standby(standby), .one_shot_start(one_shot_start)
);

// [testbench/tar_host_model.sv]
`timescale 1ns/100ps
`include "tar_defs.svh"
// ******
// Bus host: drives the clock, releases data to the pull-up.
// ******
module tar_host_model #(
  parameter logic [6:0] SLAVE = 7'h4c
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  localparam int H = 10;

  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic start();
    sda_drv = 1'b1;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda_drv = 1'b0;
    tick(H);
    scl = 1'b0;
    tick(2);
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda_drv = 1'b1;
    tick(H);
  endtask : stop

  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    tick(H);
    scl = 1'b1;
    tick(H / 2);
    s = sda_line;
    tick(H / 2);
    scl = 1'b0;
    tick(2);
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // Every read ends with a NACK.
  task automatic rd_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(1'b1, s);
  endtask : rd_byte

  task automatic reg_write(input logic [7:0] cmd, input logic [7:0] v);
    logic a;
    start();
    wr_byte({SLAVE, 1'b0}, a);
    wr_byte(cmd, a);
    wr_byte(v, a);
    stop();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] cmd, output logic [7:0] v);
    logic a;
    start();
    wr_byte({SLAVE, 1'b0}, a);
    wr_byte(cmd, a);
    start();
    wr_byte({SLAVE, 1'b1}, a);
    rd_byte(v);
    stop();
  endtask : reg_read

  task automatic ara_read(output logic ack, output logic [7:0] v);
    start();
    wr_byte({`TAR_ARA_ADDR, 1'b1}, ack);
    rd_byte(v);
    stop();
  endtask : ara_read
endmodule : tar_host_model

// [testbench/tar_alert_top_test.sv]
`timescale 1ns/100ps
`include "tar_defs.svh"
module tar_alert_top_test;
  import tar_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         meas_stb;
  tar_byte_type local_temp;
  tar_byte_type remote_temp;
  tar_byte_type lim [6];
  logic         remote_open;
  logic         conv_busy;
  logic         standby;
  logic         scl;
  logic         host_sda;
  logic         sda_w;
  logic         sda_out;
  logic         sda_oe;
  logic         alert_out;
  logic         alert_oe;
  logic         alert_w;
  logic         shot;
  logic         a;
  tar_byte_type d;
  tar_byte_type e;
  logic [31:0]  seed;
  int           pulses = 0;
  int           high_cyc = 0;
  int           mismatches = 0;
  int           n_tests = 0;
  localparam tar_byte_type CMD [6] = '{`TAR_CMD_CONFIG, `TAR_CMD_ABS, `TAR_CMD_MAKER, `TAR_CMD_REVISION,
                                       `TAR_CMD_ONESHOT, 8'h33};
  localparam tar_byte_type EXP [6] = '{8'h00, 8'h00, `TAR_MAKER_DEFAULT, `TAR_REVISION_DEFAULT, 8'hff, 8'hff};

  assign sda_w   = host_sda & ~(sda_oe & ~sda_out);
  assign alert_w = ~(alert_oe & ~alert_out);

  tar_alert_top dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_out(alert_out), .alert_oe(alert_oe), .meas_stb(meas_stb), .local_temp(local_temp),
    .remote_temp(remote_temp), .local_high_limit(lim[0]), .local_low_limit(lim[1]),
    .local_crit_limit(lim[2]), .remote_high_limit(lim[3]), .remote_low_limit(lim[4]),
    .remote_crit_limit(lim[5]), .remote_open(remote_open), .conv_busy(conv_busy),
    .standby(standby), .one_shot_start(shot)
  );

  tar_host_model #(.SLAVE(`TAR_SLAVE_DEFAULT)) host (.clk(clk), .sda_line(sda_w), .scl(scl), .sda_drv(host_sda));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (shot)
      pulses++;

  always @(posedge clk)
    if (alert_w)
      high_cyc++;

  initial
  begin
    #2_000_000;
    mismatches++;
    tally_and_finish();
  end

  function automatic tar_byte_type rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed[7:0];
  endfunction : rnd

  function automatic tar_byte_type st(input tar_byte_type l, input tar_byte_type r, input logic o);
    return {1'b0, $signed(l) > $signed(lim[0]), $signed(l) < $signed(lim[1]), $signed(r) > $signed(lim[3]),
            $signed(r) < $signed(lim[4]), o, $signed(r) > $signed(lim[5]), $signed(l) > $signed(lim[2])};
  endfunction : st

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // A reading lands; the expected status collects in e.
  task automatic meas(input tar_byte_type l, input tar_byte_type r, input logic o);
    local_temp  = l;
    remote_temp = r;
    remote_open = o;
    meas_stb    = 1'b1;
    e           = e | st(l, r, o);
    @(posedge clk);
    #1;
    meas_stb = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : meas

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    seed        = 32'haece;
    rst_n       = 1'b0;
    meas_stb    = 1'b0;
    local_temp  = 8'h00;
    remote_temp = 8'h00;
    remote_open = 1'b0;
    conv_busy   = 1'b0;
    standby     = 1'b1;
    lim         = '{8'h46, 8'h00, 8'h55, 8'h46, 8'h00, 8'h55};
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk(alert_w, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      host.reg_read(CMD[k], d);
      chk(d, EXP[k]);
    end
    host.reg_write(`TAR_CMD_ABS, 8'hff);
    host.reg_read(`TAR_CMD_ABS, d);
    chk(d, 8'h01);
    host.reg_write(`TAR_CMD_ABS, 8'h00);
    host.reg_write(`TAR_CMD_ONESHOT, 8'h5a);
    chk(pulses[7:0], 8'h01);
    host.reg_read(`TAR_CMD_ONESHOT, d);
    chk(d, 8'hff);
    standby = 1'b0;
    host.reg_write(`TAR_CMD_ONESHOT, 8'h5a);
    standby   = 1'b1;
    conv_busy = 1'b1;
    host.reg_write(`TAR_CMD_ONESHOT, 8'h5a);
    host.reg_read(`TAR_CMD_STATUS, d);
    chk(d, 8'h80);
    chk(alert_w, 1'b1);
    conv_busy = 1'b0;
    chk(pulses[7:0], 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      foreach (lim[k])
        lim[k] = rnd();
      e = 8'h00;
      repeat (2)
        meas(rnd(), rnd(), rnd() > 8'hc0);
      chk(alert_w, !(|(e & `TAR_ALARM_BITS)));
      host.reg_read(`TAR_CMD_STATUS, d);
      chk(d, e);
      chk(alert_w, 1'b1);
      host.reg_read(`TAR_CMD_CONFIG, d);
      chk(d, (|(e & `TAR_ALARM_BITS)) ? 8'h80 : 8'h00);
      host.reg_read(`TAR_CMD_STATUS, d);
      chk(d, 8'h00);
      host.reg_write(`TAR_CMD_CONFIG, 8'h00);
    end
    lim = '{8'h46, 8'h00, 8'h55, 8'h46, 8'h00, 8'h55};
    e   = 8'h00;
    meas(8'h50, 8'h10, 1'b0);
    host.reg_read(`TAR_CMD_STATUS, d);
    meas(8'h50, 8'h10, 1'b0);
    chk(alert_w, 1'b1);
    host.reg_write(`TAR_CMD_CONFIG, 8'h00);
    chk(alert_w, 1'b0);
    host.ara_read(a, d);
    chk(a, 1'b1);
    chk(d, {`TAR_SLAVE_DEFAULT, 1'b1});
    chk(alert_w, 1'b1);
    host.reg_read(`TAR_CMD_CONFIG, d);
    chk(d, 8'h80);
    host.reg_read(`TAR_CMD_STATUS, d);
    chk(d, 8'h40);
    host.reg_write(`TAR_CMD_CONFIG, 8'h00);
    host.ara_read(a, d);
    chk(a, 1'b0);
    chk(d, 8'hff);
    host.reg_write(`TAR_CMD_ABS, 8'h01);
    meas(8'h50, 8'h10, 1'b0);
    chk(alert_w, 1'b0);
    high_cyc = 0;
    host.reg_read(`TAR_CMD_STATUS, d);
    chk(d, 8'h40);
    chk(high_cyc[7:0], 8'h00);
    host.reg_read(`TAR_CMD_CONFIG, d);
    chk(d, 8'h00);
    host.ara_read(a, d);
    chk(a, 1'b0);
    meas(8'h10, 8'h10, 1'b0);
    chk(alert_w, 1'b1);
    host.reg_write(`TAR_CMD_ABS, 8'h00);
    tally_and_finish();
  end
endmodule : tar_alert_top_test
